// file: hdl/mqe_monitor.sv
// Memory controller queues, scheduler, major mode control and event counters.
`timescale 1ns/10ps
module mqe_monitor (
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic nrst_in,
  // APB register port.
  input wire mqe_pkg::mqe_apb_req_t apb_in,
  output logic pready_out,
  output logic [31:0] prdata_out,
  output logic pslverr_out,
  // Home agent requests and credits.
  input wire mqe_pkg::mqe_req_t ha_req_in,
  output logic req_ready_out,
  output logic [2:0] rd_credit_out,
  output logic [2:0] wr_credit_out,
  output logic wr_done_out,
  output logic rd_resp_valid_out,
  output logic [31:0] rd_resp_data_out,
  output logic [15:0] rd_resp_addr_out,
  // Memory column command port.
  output mqe_pkg::mqe_col_t col_out,
  input wire logic col_ready_in,
  // Buffered memory path.
  input wire logic buffer_retry_in,
  input wire logic [5:0] buffered_write_fill_level_in,
  // Events and mode.
  output mqe_pkg::mqe_evt_t evt_out,
  output mqe_pkg::mqe_mode_t mode_out
);

  mqe_pkg::mqe_state_t st_q;
  mqe_pkg::mqe_state_t st_d;
  logic [3:0] rv;
  logic [3:0] wv;
  logic [3:0] wmv;
  logic [3:0] wok;
  logic [2:0] rcnt;
  logic [2:0] wcnt;
  logic [2:0] wm;
  logic rfull;
  logic wfull;
  logic req_ok;
  logic acc;
  logic col_fire;
  logic rpq_busy;
  logic wpq_busy;

  function automatic logic [2:0] mqe_count(input logic [3:0] v);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < 4; i++) begin
      n = n + {2'b00, v[i]};
    end
    return n;
  endfunction

  // Lowest set index with a found flag on top.
  function automatic logic [2:0] mqe_first(input logic [3:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 3; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 2'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic [5:0] mqe_inc(input mqe_pkg::mqe_ctl_t c, input mqe_pkg::mqe_evt_t e);
    logic hit;
    hit = 1'b0;
    case (c.code)
      mqe_pkg::MQE_EV_RPQ_BUSY: hit = e.rpq_busy;
      mqe_pkg::MQE_EV_RPQ_ALLOC: hit = e.rpq_alloc;
      mqe_pkg::MQE_EV_WPQ_FULL: hit = e.wpq_full;
      mqe_pkg::MQE_EV_WPQ_BUSY: hit = e.wpq_busy;
      mqe_pkg::MQE_EV_WPQ_ALLOC: hit = e.wpq_alloc;
      mqe_pkg::MQE_EV_RD_MATCH: hit = e.rd_match;
      mqe_pkg::MQE_EV_WR_MATCH: hit = e.wr_match;
      mqe_pkg::MQE_EV_PUSH: hit = e.push & ((c.umask[0] & e.push_wmm) | (c.umask[1] & !e.push_wmm));
      mqe_pkg::MQE_EV_SWITCH: hit = e.mode_switch & (|(c.umask[2:0] & {e.sw_retry, e.sw_starve, e.sw_low}));
      mqe_pkg::MQE_EV_DENIED: hit = e.denied;
      default: begin
        // Column events cover all ranks: bit 3 of the code picks writes, bits 2:0 the rank.
        hit = (c.code[7:4] == mqe_pkg::MQE_EV_COL_GRP) & e.col & (e.col_write == c.code[3]) &
              (e.col_rank == c.code[2:0]) & (|(c.umask & (8'h01 << e.col_bank)));
      end
    endcase
    return (c.code == mqe_pkg::MQE_EV_FILL) ? e.fill : {5'h00, hit};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Queue views.

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      rv[i] = st_q.read_pending_queue[i].valid;
      wv[i] = st_q.write_pending_queue[i].valid;
      // An entry already copied into the column register is frozen, so nothing merges into it.
      wmv[i] = st_q.write_pending_queue[i].valid & (st_q.write_pending_queue[i].addr == ha_req_in.addr) &
               !(st_q.col.valid & st_q.col.write & (st_q.col_idx == 2'(i)));
      wok[i] = st_q.write_pending_queue[i].valid;
      for (int j = 0; j < 4; j++) begin
        // A write may not pass an older read of its own address.
        if (st_q.read_pending_queue[j].valid && (st_q.read_pending_queue[j].addr == st_q.write_pending_queue[i].addr)) begin
          wok[i] = 1'b0;
        end
      end
    end
  end

  assign rcnt = mqe_count(rv);
  assign wcnt = mqe_count(wv);
  assign wm = mqe_first(wmv);
  assign rfull = (rcnt == 3'(mqe_pkg::MQE_RPQ_DEPTH));
  assign wfull = (wcnt == 3'(mqe_pkg::MQE_WPQ_DEPTH));
  assign rpq_busy = (rcnt != 3'h0);
  assign wpq_busy = (wcnt != 3'h0);
  // A full write queue refuses every request, reads included.
  assign req_ok = !wfull & (ha_req_in.write | !rfull | wm[2]);
  assign acc = ha_req_in.valid & req_ok;
  assign col_fire = st_q.col.valid & col_ready_in;

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    logic [2:0] slot;
    logic [2:0] rc;
    logic [2:0] wc;
    logic want;
    logic low;
    logic stv;
    logic [31:0] rd;
    logic [5:0] word;
    st_d = st_q;
    slot = 3'h0;
    rc = mqe_first(rv);
    wc = mqe_first(wok);
    want = 1'b0;
    low = 1'b0;
    stv = 1'b0;
    rd = 32'h0000_0000;
    word = apb_in.paddr[7:2];
    st_d.evt = '0;
    st_d.wr_done = 1'b0;
    st_d.rd_resp_valid = 1'b0;
    st_d.evt.rpq_busy = rpq_busy;
    st_d.evt.wpq_busy = wpq_busy;
    st_d.evt.wpq_full = wfull;
    st_d.evt.fill = (buffered_write_fill_level_in > mqe_pkg::MQE_FILL_MAX) ?
                    mqe_pkg::MQE_FILL_MAX : buffered_write_fill_level_in;

    // Entries leave the queues only when memory takes their column command.
    if (col_fire) begin
      st_d.col.valid = 1'b0;
      if (st_q.col.write) begin
        st_d.write_pending_queue[st_q.col_idx].valid = 1'b0;
        st_d.evt.push = 1'b1;
        st_d.evt.push_wmm = (st_q.mode == mqe_pkg::MQE_MODE_WRITE);
      end else begin
        st_d.read_pending_queue[st_q.col_idx].valid = 1'b0;
      end
      st_d.evt.col = 1'b1;
      st_d.evt.col_write = st_q.col.write;
      st_d.evt.col_rank = st_q.col.addr[mqe_pkg::MQE_RANK_LSB +: 3];
      st_d.evt.col_bank = st_q.col.addr[mqe_pkg::MQE_BANK_LSB +: 3];
    end

    if (acc && !ha_req_in.write && wm[2]) begin
      st_d.rd_resp_valid = 1'b1;
      st_d.rd_resp_data = st_q.write_pending_queue[wm[1:0]].data;
      st_d.rd_resp_addr = ha_req_in.addr;
      st_d.evt.rd_match = 1'b1;
    end else if (acc && !ha_req_in.write) begin
      slot = mqe_first(~rv);
      st_d.read_pending_queue[slot[1:0]].valid = 1'b1;
      st_d.read_pending_queue[slot[1:0]].addr = ha_req_in.addr;
      st_d.evt.rpq_alloc = 1'b1;
    end else if (acc && wm[2]) begin
      for (int b = 0; b < 4; b++) begin
        if (ha_req_in.be[b]) begin
          st_d.write_pending_queue[wm[1:0]].data[8*b +: 8] = ha_req_in.data[8*b +: 8];
        end
      end
      st_d.write_pending_queue[wm[1:0]].be = st_q.write_pending_queue[wm[1:0]].be | ha_req_in.be;
      st_d.evt.wr_match = 1'b1;
      st_d.wr_done = 1'b1;
    end else if (acc) begin
      slot = mqe_first(~wv);
      st_d.write_pending_queue[slot[1:0]].valid = 1'b1;
      st_d.write_pending_queue[slot[1:0]].addr = ha_req_in.addr;
      st_d.write_pending_queue[slot[1:0]].data = ha_req_in.data;
      st_d.write_pending_queue[slot[1:0]].be = ha_req_in.be;
      st_d.evt.wpq_alloc = 1'b1;
      st_d.wr_done = 1'b1;
    end

    // One command in flight; the mode picks the preferred queue, the other fills idle slots.
    if (!st_q.col.valid) begin
      if (rc[2] && ((st_q.mode == mqe_pkg::MQE_MODE_READ) || !wc[2])) begin
        st_d.col = '{valid: 1'b1, write: 1'b0, addr: st_q.read_pending_queue[rc[1:0]].addr, data: 32'h0000_0000, be: 4'h0};
        st_d.col_idx = rc[1:0];
      end else if (wc[2]) begin
        st_d.col = '{valid: 1'b1, write: 1'b1, addr: st_q.write_pending_queue[wc[1:0]].addr,
                     data: st_q.write_pending_queue[wc[1:0]].data, be: st_q.write_pending_queue[wc[1:0]].be};
        st_d.col_idx = wc[1:0];
      end
    end

    // Major mode control with a minimum dwell between switches.
    if (st_q.dwell != 4'h0) begin
      st_d.dwell = st_q.dwell - 4'h1;
    end
    if (st_q.mode == mqe_pkg::MQE_MODE_READ) begin
      want = (wcnt >= st_q.hi_thr) | (!rpq_busy & wpq_busy);
      st_d.starve = 8'h00;
    end else begin
      low = (wcnt <= st_q.lo_thr) & rpq_busy;
      stv = (st_q.starve >= st_q.starve_lim) & rpq_busy;
      want = low | stv | buffer_retry_in;
      if (rpq_busy && (st_q.starve != 8'hFF)) begin
        st_d.starve = st_q.starve + 8'h01;
      end else if (!rpq_busy) begin
        st_d.starve = 8'h00;
      end
    end
    if (want && (st_q.dwell == 4'h0)) begin
      st_d.dwell = mqe_pkg::MQE_MIN_DWELL;
      st_d.starve = 8'h00;
      if (st_q.mode == mqe_pkg::MQE_MODE_WRITE) begin
        st_d.mode = mqe_pkg::MQE_MODE_READ;
        st_d.evt.mode_switch = 1'b1;
        st_d.evt.sw_low = low;
        st_d.evt.sw_starve = stv;
        st_d.evt.sw_retry = buffer_retry_in;
      end else begin
        st_d.mode = mqe_pkg::MQE_MODE_WRITE;
      end
    end else if (want) begin
      st_d.evt.denied = 1'b1;
    end

    // Counters take events of the previous cycle; a software load wins over counting.
    for (int i = 0; i < mqe_pkg::MQE_CNT_NUM; i++) begin
      if (st_q.ctl[i].en) begin
        st_d.cnt[i] = st_q.cnt[i] + {26'h0, mqe_inc(st_q.ctl[i], st_q.evt)};
      end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB: read data and error are captured in the setup cycle.

    if (apb_in.psel && !apb_in.penable) begin
      st_d.pslverr = 1'b0;
      if (apb_in.paddr[1:0] != 2'b00) begin
        st_d.pslverr = 1'b1;
      end else if (apb_in.paddr < mqe_pkg::MQE_OFS_CNT) begin
        rd[mqe_pkg::MQE_CTL_EN_BIT] = st_q.ctl[word[1:0]].en;
        rd[mqe_pkg::MQE_CTL_UMASK_LSB +: 8] = st_q.ctl[word[1:0]].umask;
        rd[mqe_pkg::MQE_CTL_CODE_LSB +: 8] = st_q.ctl[word[1:0]].code;
      end else if (apb_in.paddr < mqe_pkg::MQE_OFS_STATUS) begin
        rd = st_q.cnt[word[1:0]];
      end else if (apb_in.paddr == mqe_pkg::MQE_OFS_STATUS) begin
        rd[mqe_pkg::MQE_ST_RCNT_LSB +: 3] = rcnt;
        rd[mqe_pkg::MQE_ST_WCNT_LSB +: 3] = wcnt;
        rd[mqe_pkg::MQE_ST_MODE_BIT] = st_q.mode;
        rd[mqe_pkg::MQE_ST_COLP_BIT] = st_q.col.valid;
      end else if (apb_in.paddr == mqe_pkg::MQE_OFS_CFG) begin
        rd[mqe_pkg::MQE_CFG_LO_LSB +: 3] = st_q.lo_thr;
        rd[mqe_pkg::MQE_CFG_HI_LSB +: 3] = st_q.hi_thr;
        rd[mqe_pkg::MQE_CFG_STV_LSB +: 8] = st_q.starve_lim;
      end else begin
        st_d.pslverr = 1'b1;
      end
      st_d.prdata = rd;
    end
    if (apb_in.psel && apb_in.penable && apb_in.pwrite && !st_q.pslverr) begin
      if (apb_in.paddr < mqe_pkg::MQE_OFS_CNT) begin
        st_d.ctl[word[1:0]].en = apb_in.pwdata[mqe_pkg::MQE_CTL_EN_BIT];
        st_d.ctl[word[1:0]].umask = apb_in.pwdata[mqe_pkg::MQE_CTL_UMASK_LSB +: 8];
        st_d.ctl[word[1:0]].code = apb_in.pwdata[mqe_pkg::MQE_CTL_CODE_LSB +: 8];
      end else if (apb_in.paddr < mqe_pkg::MQE_OFS_STATUS) begin
        st_d.cnt[word[1:0]] = apb_in.pwdata;
      end else if (apb_in.paddr == mqe_pkg::MQE_OFS_CFG) begin
        st_d.lo_thr = apb_in.pwdata[mqe_pkg::MQE_CFG_LO_LSB +: 3];
        st_d.hi_thr = apb_in.pwdata[mqe_pkg::MQE_CFG_HI_LSB +: 3];
        st_d.starve_lim = apb_in.pwdata[mqe_pkg::MQE_CFG_STV_LSB +: 8];
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      st_q <= '0;
      st_q.lo_thr <= mqe_pkg::MQE_LO_THR_RST;
      st_q.hi_thr <= mqe_pkg::MQE_HI_THR_RST;
      st_q.starve_lim <= mqe_pkg::MQE_STV_LIM_RST;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign pready_out = apb_in.psel & apb_in.penable;
  assign prdata_out = st_q.prdata;
  assign pslverr_out = st_q.pslverr & apb_in.psel & apb_in.penable;
  assign req_ready_out = req_ok;
  assign rd_credit_out = 3'(mqe_pkg::MQE_RPQ_DEPTH) - rcnt;
  assign wr_credit_out = 3'(mqe_pkg::MQE_WPQ_DEPTH) - wcnt;
  assign wr_done_out = st_q.wr_done;
  assign rd_resp_valid_out = st_q.rd_resp_valid;
  assign rd_resp_data_out = st_q.rd_resp_data;
  assign rd_resp_addr_out = st_q.rd_resp_addr;
  assign col_out = st_q.col;
  assign evt_out = st_q.evt;
  assign mode_out = st_q.mode;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!nrst_in);

  a_rpq_busy_evt: assert property (1'b1 |=> st_q.evt.rpq_busy == $past(rpq_busy))
    else $error("read queue busy event does not follow occupancy");
  a_rpq_alloc_evt: assert property (acc && !ha_req_in.write && !wm[2] |=> st_q.evt.rpq_alloc && rpq_busy)
    else $error("read allocation without event");
  a_rpq_hold: assert property ((rcnt < $past(rcnt)) |-> $past(col_fire) && !$past(st_q.col.write))
    else $error("read entry freed before its column command");
  a_wpq_full_refuse: assert property (wfull |-> !req_ready_out ##1 st_q.evt.wpq_full)
    else $error("full write queue accepted a request or missed its event");
  a_wpq_busy_evt: assert property (wpq_busy |=> st_q.evt.wpq_busy)
    else $error("write queue busy event missing");
  a_wpq_alloc_evt: assert property (acc && ha_req_in.write && !wm[2] |=> st_q.evt.wpq_alloc && wr_done_out)
    else $error("write allocation without event or completion");
  a_wpq_free: assert property ((wcnt < $past(wcnt)) |-> $past(col_fire) && $past(st_q.col.write))
    else $error("write entry freed before issue");
  a_read_fwd: assert property (acc && !ha_req_in.write && wm[2] |=>
    rd_resp_valid_out && st_q.evt.rd_match &&
    (rcnt == $past(rcnt) - {2'b00, $past(col_fire && !st_q.col.write)}))
    else $error("matching read not served from the write queue");
  a_write_merge: assert property (acc && ha_req_in.write && wm[2] |=> st_q.evt.wr_match && !st_q.evt.wpq_alloc)
    else $error("matching write allocated a new entry");
  a_switch_cause: assert property (st_q.evt.mode_switch |->
    st_q.mode == mqe_pkg::MQE_MODE_READ && $past(st_q.mode) == mqe_pkg::MQE_MODE_WRITE &&
    (st_q.evt.sw_low || st_q.evt.sw_starve || st_q.evt.sw_retry))
    else $error("mode switch event without a write-to-read change");
  a_denied_dwell: assert property (st_q.evt.denied |-> $past(st_q.dwell) != 4'h0 && st_q.mode == $past(st_q.mode))
    else $error("denied event while a switch was possible");
  a_count_step: assert property (st_q.ctl[0].en && st_q.ctl[0].code != mqe_pkg::MQE_EV_FILL &&
    !(apb_in.psel && apb_in.penable && apb_in.pwrite) |=> (st_q.cnt[0] - $past(st_q.cnt[0])) <= 32'h0000_0001)
    else $error("counter stepped by more than one");

  // Every command that memory takes must show up as a column event in the next cycle.
  // Only writes are pushes on the buffered path, so push must follow the command kind.
  a_col_event: assert property (col_fire |=>
    st_q.evt.col && (st_q.evt.col_write == $past(st_q.col.write)) && (st_q.evt.push == $past(st_q.col.write)))
    else $error("column command taken without a matching event");

  // The fill level may never add more than the documented per-cycle maximum.
  a_fill_clamp: assert property (st_q.evt.fill <= mqe_pkg::MQE_FILL_MAX)
    else $error("buffer fill event above its per-cycle limit");

  c_read_fwd: cover property (acc && !ha_req_in.write && wm[2]);
  c_write_merge: cover property (acc && ha_req_in.write && wm[2]);
  c_mode_switch: cover property (st_q.evt.mode_switch);
  c_mode_denied: cover property (st_q.evt.denied);
endmodule

// file: hdl/mqe_pkg.sv
// Constants, types and carriers of the memory controller queue event monitor.
// Notes on behaviour
// - Read queue non-empty cycles raise event 0x11.
// - Each read queue allocation raises event 0x10.
// - Read entry held until its column command issues.
// - Write queue full raises 0x22, refuses requests.
// - Write queue non-empty cycles raise event 0x21.
// - Each write queue allocation raises event 0x20.
// - Write done once posted; freed after issue.
// - Requests search write queue for same address.
// - Reads may overtake; matching reads take queued data.
// - Matching writes merge only their own bytes.
// - Queue matches raise 0x23 read, 0x24 write.
// - Rank seven read column 0xB7, bank mask.
// - Rank zero/one write column 0xB8/0xB9, bank mask.
// - Buffered write push 0x90, mode selects mask.
// - Buffer fill level 0x91 adds up to 32.
// - Write-to-read mode switch 0xC0 with cause mask.
// - Denied major mode request raises event 0xC1.
// - Four counters take any event, one per cycle except fill level.
package mqe_pkg;
  localparam int MQE_RPQ_DEPTH = 4;
  localparam int MQE_WPQ_DEPTH = 4;
  localparam int MQE_CNT_NUM = 4;
  localparam int MQE_RANK_LSB = 6;
  localparam int MQE_BANK_LSB = 3;
  localparam logic [7:0] MQE_EV_RPQ_ALLOC = 8'h10;
  localparam logic [7:0] MQE_EV_RPQ_BUSY = 8'h11;
  localparam logic [7:0] MQE_EV_WPQ_ALLOC = 8'h20;
  localparam logic [7:0] MQE_EV_WPQ_BUSY = 8'h21;
  localparam logic [7:0] MQE_EV_WPQ_FULL = 8'h22;
  localparam logic [7:0] MQE_EV_RD_MATCH = 8'h23;
  localparam logic [7:0] MQE_EV_WR_MATCH = 8'h24;
  localparam logic [7:0] MQE_EV_PUSH = 8'h90;
  localparam logic [7:0] MQE_EV_FILL = 8'h91;
  localparam logic [7:0] MQE_EV_SWITCH = 8'hC0;
  localparam logic [7:0] MQE_EV_DENIED = 8'hC1;
  localparam logic [3:0] MQE_EV_COL_GRP = 4'hB;
  localparam logic [5:0] MQE_FILL_MAX = 6'h20;
  // Register offsets and field positions.
  localparam logic [7:0] MQE_OFS_CTL = 8'h00;
  localparam logic [7:0] MQE_OFS_CNT = 8'h10;
  localparam logic [7:0] MQE_OFS_STATUS = 8'h20;
  localparam logic [7:0] MQE_OFS_CFG = 8'h24;
  localparam int MQE_CTL_CODE_LSB = 0;
  localparam int MQE_CTL_UMASK_LSB = 8;
  localparam int MQE_CTL_EN_BIT = 22;
  localparam int MQE_CFG_LO_LSB = 0;
  localparam int MQE_CFG_HI_LSB = 4;
  localparam int MQE_CFG_STV_LSB = 8;
  localparam int MQE_ST_RCNT_LSB = 0;
  localparam int MQE_ST_WCNT_LSB = 4;
  localparam int MQE_ST_MODE_BIT = 8;
  localparam int MQE_ST_COLP_BIT = 9;
  // Values after reset and cycle counts.
  localparam logic [2:0] MQE_LO_THR_RST = 3'h1;
  localparam logic [2:0] MQE_HI_THR_RST = 3'h3;
  localparam logic [7:0] MQE_STV_LIM_RST = 8'h10;
  localparam logic [3:0] MQE_MIN_DWELL = 4'h8;

  typedef enum logic [0:0] {
    MQE_MODE_READ = 1'b0,
    MQE_MODE_WRITE = 1'b1
  } mqe_mode_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
    logic [31:0] data;
    logic [3:0] be;
  } mqe_req_t;

  typedef struct packed {
    logic valid;
    logic [15:0] addr;
  } mqe_rent_t;

  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic [31:0] data;
    logic [3:0] be;
  } mqe_went_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
    logic [31:0] data;
    logic [3:0] be;
  } mqe_col_t;

  typedef struct packed {
    logic en;
    logic [7:0] umask;
    logic [7:0] code;
  } mqe_ctl_t;

  typedef struct packed {
    logic rpq_busy;
    logic rpq_alloc;
    logic wpq_full;
    logic wpq_busy;
    logic wpq_alloc;
    logic rd_match;
    logic wr_match;
    logic col;
    logic col_write;
    logic [2:0] col_rank;
    logic [2:0] col_bank;
    logic push;
    logic push_wmm;
    logic mode_switch;
    logic sw_low;
    logic sw_starve;
    logic sw_retry;
    logic denied;
    logic [5:0] fill;
  } mqe_evt_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } mqe_apb_req_t;

  typedef struct packed {
    mqe_rent_t [MQE_RPQ_DEPTH-1:0] read_pending_queue;
    mqe_went_t [MQE_WPQ_DEPTH-1:0] write_pending_queue;
    mqe_col_t col;
    logic [1:0] col_idx;
    mqe_mode_t mode;
    logic [3:0] dwell;
    logic [7:0] starve;
    logic [2:0] lo_thr;
    logic [2:0] hi_thr;
    logic [7:0] starve_lim;
    mqe_ctl_t [MQE_CNT_NUM-1:0] ctl;
    logic [MQE_CNT_NUM-1:0][31:0] cnt;
    mqe_evt_t evt;
    logic [31:0] prdata;
    logic pslverr;
    logic rd_resp_valid;
    logic [31:0] rd_resp_data;
    logic [15:0] rd_resp_addr;
    logic wr_done;
  } mqe_state_t;
endpackage

// file: tb/mqe_mem_model.sv
// Memory side model: takes column commands slowly, or not at all while stalled.
`timescale 1ns/10ps
module mqe_mem_model #(
  parameter logic [15:0] WATCH_ADDR = 16'h0000
) (
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic nrst_in,
  // Column command side.
  input wire logic stall_in,
  input wire mqe_pkg::mqe_col_t col_in,
  output logic col_ready_out,
  // Observation.
  output logic [7:0] taken_out,
  output logic [31:0] watch_data_out
);
  // Ready only every other cycle, so the scheduler must hold its command across a refusal.
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      col_ready_out <= 1'b0;
      taken_out <= 8'h00;
      watch_data_out <= 32'h0000_0000;
    end else begin
      col_ready_out <= !stall_in && !col_ready_out;
      if (col_in.valid && col_ready_out) begin
        taken_out <= taken_out + 8'h01;
        if (col_in.write && col_in.addr == WATCH_ADDR) begin
          watch_data_out <= col_in.data;
        end
      end
    end
  end
endmodule

// file: tb/mqe_monitor_tb.sv
// Self-checking testbench of the queue event monitor.
`timescale 1ns/10ps
module mqe_monitor_tb;
  logic mclk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic stall = 1'b1;
  logic retry = 1'b0;
  logic [5:0] fill = 6'h00;
  mqe_pkg::mqe_apb_req_t apb = '0;
  mqe_pkg::mqe_req_t req = '0;
  mqe_pkg::mqe_col_t col;
  mqe_pkg::mqe_evt_t evt;
  mqe_pkg::mqe_mode_t mode;
  logic pready, pslverr, col_ready, ready, done, rv, err;
  logic [31:0] prdata, rdat, rd, wdat;
  logic [15:0] raddr;
  logic [2:0] rcr, wcr;
  logic [7:0] taken;
  int mismatches = 0;
  int check_count = 0;
  logic [7:0] codes [8] = '{8'h10, 8'h20, 8'h23, 8'h24, 8'hB7, 8'hB8, 8'hB9, 8'h90};
  logic [7:0] masks [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h02, 8'h20, 8'h03};
  logic [31:0] counts [8] = '{32'h1, 32'h4, 32'h1, 32'h1, 32'h1, 32'h1, 32'h1, 32'h4};

  mqe_monitor DUT (.mclk_in(mclk_in), .nrst_in(nrst_in), .apb_in(apb), .pready_out(pready), .prdata_out(prdata),
    .pslverr_out(pslverr), .ha_req_in(req), .req_ready_out(ready), .rd_credit_out(rcr), .wr_credit_out(wcr),
    .wr_done_out(done), .rd_resp_valid_out(rv), .rd_resp_data_out(rdat), .rd_resp_addr_out(raddr),
    .col_out(col), .col_ready_in(col_ready), .buffer_retry_in(retry), .buffered_write_fill_level_in(fill),
    .evt_out(evt), .mode_out(mode));
  mqe_mem_model #(.WATCH_ADDR(16'h0068)) MEM (.mclk_in(mclk_in), .nrst_in(nrst_in), .stall_in(stall),
    .col_in(col), .col_ready_out(col_ready), .taken_out(taken), .watch_data_out(wdat));

  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic timeout();
    mismatches++;
    $display("[ERR] t=%0t seen=%h exp=%h", $time, 32'h0, 32'h1);
    end_of_test();
  endtask

  task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk_in);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge mclk_in);
    apb.penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge mclk_in);
      if (pready === 1'b1) break;
    end
    if (n == 20) timeout();
    rd = prdata;
    err = pslverr;
    apb <= '0;
  endtask

  // Returns one nanosecond after the taking edge, so the one-cycle answers can be read at once.
  task automatic send(input logic wr, input logic [15:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    @(posedge mclk_in);
    req <= '{valid: 1'b1, write: wr, addr: a, data: d, be: be};
    for (n = 0; n < 50; n++) begin
      @(posedge mclk_in);
      if (ready === 1'b1) break;
    end
    if (n == 50) timeout();
    req.valid <= 1'b0;
    #1;
  endtask

  initial begin
    forever #2.5 mclk_in = ~mclk_in;
  end

  initial begin
    int n;
    repeat (20) @(posedge mclk_in);
    nrst_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    #1;
    chk({rcr, wcr, ready, mode}, {3'h4, 3'h4, 1'b1, 1'b0});
    apb_xfer(1'b0, mqe_pkg::MQE_OFS_CFG, 32'h0);
    chk(rd, 32'h0000_1031);
    apb_xfer(1'b0, 8'h28, 32'h0);
    chk({31'h0, err}, 32'h1);
    for (int i = 0; i < 4; i++) apb_xfer(1'b1, 8'(4 * i), {9'h0, 1'b1, 6'h0, masks[i], codes[i]});
    // The first write parks in the stalled column port, so later ones stay matchable in the queue.
    send(1'b1, 16'h0008, 32'hCAFE_0001, 4'hF);
    // A retry while the dwell runs asks for a switch that must be denied.
    @(posedge mclk_in);
    retry <= 1'b1;
    repeat (3) @(posedge mclk_in);
    retry <= 1'b0;
    send(1'b1, 16'h0068, 32'h1122_3344, 4'hF);
    chk({31'h0, done}, 32'h1);
    send(1'b1, 16'h0068, 32'hAABB_CCDD, 4'h3);
    chk({31'h0, done}, 32'h1);
    send(1'b0, 16'h0068, 32'h0, 4'hF);
    chk(rdat, 32'h1122_CCDD);
    chk({rv, raddr}, {1'b1, 16'h0068});
    send(1'b0, 16'h01D0, 32'h0, 4'hF);
    chk({rv, rcr, wcr}, {1'b0, 3'h3, 3'h2});
    send(1'b1, 16'h0010, 32'h5555_0010, 4'hF);
    send(1'b1, 16'h0118, 32'h6666_0118, 4'hF);
    chk({ready, wcr}, {1'b0, 3'h0});
    repeat (2) @(posedge mclk_in);
    #1;
    chk({evt.rpq_busy, evt.wpq_busy, evt.wpq_full}, 3'h7);
    for (int i = 0; i < 4; i++) begin
      apb_xfer(1'b0, 8'(16 + 4 * i), 32'h0);
      chk(rd, counts[i]);
    end
    for (int i = 4; i < 8; i++) begin
      apb_xfer(1'b1, 8'(4 * i - 16), {9'h0, 1'b1, 6'h0, masks[i], codes[i]});
      apb_xfer(1'b1, 8'(4 * i), 32'h0);
    end
    stall <= 1'b0;
    for (n = 0; n < 400; n++) begin
      @(posedge mclk_in);
      if (rcr === 3'h4 && wcr === 3'h4 && col.valid === 1'b0) break;
    end
    if (n == 400) timeout();
    repeat (3) @(posedge mclk_in);
    for (int i = 4; i < 8; i++) begin
      apb_xfer(1'b0, 8'(4 * i), 32'h0);
      chk(rd, counts[i]);
    end
    // Fill level 0x28 is clamped to 32 and held for exactly three sampling edges.
    apb_xfer(1'b1, 8'h00, {9'h0, 1'b1, 6'h0, 8'h00, 8'h91});
    apb_xfer(1'b1, 8'h10, 32'h0);
    @(posedge mclk_in);
    fill <= 6'h28;
    repeat (3) @(posedge mclk_in);
    fill <= 6'h00;
    repeat (3) @(posedge mclk_in);
    apb_xfer(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0000_0060);
    chk({24'h0, taken}, 32'h5);
    chk(wdat, 32'h1122_CCDD);
    chk({ready, evt.rpq_busy, evt.wpq_busy}, 3'h4);
    end_of_test();
  end
endmodule
